//--- logic/iio_filter.sv
// Purpose: one input channel: pin synchroniser plus switchable low-pass filter
// Assumes: filter modelled as a persistence filter of one time constant
// Notes:   bypass still passes the three-flop synchroniser
`timescale 1ns/1ns
module iio_filter #(
  parameter int CYCLES = iio_pkg::FILT_CYCLES
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // channel
  input  wire logic pinIn,
  input  wire logic filtEn,
  output logic      state
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [2:0]    sync_r;
  logic [CW-1:0] cnt_r;
  logic          state_r;
  wire           stable  = (sync_r[2] == sync_r[1]);
  wire           differs = stable && (sync_r[1] != state_r);
  wire           done    = (cnt_r == CW'(CYCLES - 1));

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_r  <= 3'h0;
      cnt_r   <= '0;
      state_r <= 1'b0;
    end else begin
      sync_r <= {sync_r[1:0], pinIn};
      if (!differs) begin
        cnt_r <= '0;
      end else if (!filtEn || done) begin
        state_r <= sync_r[1];
        cnt_r   <= '0;
      end else begin
        cnt_r <= cnt_r + CW'(1);
      end
    end
  end
  assign state = state_r;

  filt_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    (filtEn && $changed(state_r)) |-> ($past(done) || !$past(filtEn)))
    else $error("filtered input changed early");
  bypass_pass_a: assert property (@(posedge clock) disable iff (!rstn)
    (!filtEn && differs) |=> (state_r == $past(sync_r[1])))
    else $error("unfiltered input held back");
endmodule : iio_filter

//--- logic/iio_pkg.sv
// Purpose: shared constants and types for the isolated input / relay output port
// Assumes: 32-bit AXI4-Lite register bus, 20 MHz clock
// Notes:   offsets are byte addresses of aligned words
package iio_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] OFS_INPUT  = 4'h0;
  localparam logic [3:0] OFS_RELAY  = 4'h4;
  localparam logic [3:0] OFS_FILTER = 4'h8;
  localparam logic [7:0] RELAY_RST  = 8'h00;
  localparam logic [7:0] FILTER_RST = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ       = 20000000;
  localparam int FILT_TAU_US  = 5000;
  localparam int FILT_CYCLES  = (CLK_HZ / 1000000) * FILT_TAU_US;
  // ----------------------------------------
  // bus answer codes
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] relay;
    logic [7:0] filtEn;
  } iio_ctrl_s;
endpackage : iio_pkg

//--- logic/iio_port.sv
// Purpose: eight isolated inputs read as one byte, eight relay drives, AXI4-Lite slave
// Assumes: one clock, relays energised by a high drive output
// Notes:   answers come one cycle after the request is complete
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module iio_port #(
  parameter int FILT_CYCLES = iio_pkg::FILT_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // write address and data
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // field side
  input  wire logic [7:0]  inPins,
  output logic [7:0]       relayDrive
);
  // ----------------------------------------
  // input channels
  // ----------------------------------------
  iio_pkg::iio_ctrl_s ctrl_r;
  logic [7:0]         inState;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_ch
      iio_filter #(.CYCLES(FILT_CYCLES)) u_filt (
        .clock  (clock),
        .rstn   (rstn),
        .pinIn  (inPins[gi]),
        .filtEn (ctrl_r.filtEn[gi]),
        .state  (inState[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // write path
  // ----------------------------------------
  logic        awHeld_r;
  logic        wHeld_r;
  logic [3:0]  awAddr_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        bValid_r;
  logic [1:0]  bResp_r;
  logic [7:0]  relay_r;
  logic        awReady_r;
  logic        wReady_r;

  wire awTake = s_axi_awvalid && !awHeld_r && !bValid_r;
  wire wTake  = s_axi_wvalid && !wHeld_r && !bValid_r;
  wire wrGo   = awHeld_r && wHeld_r && !bValid_r;
  wire selRly = (awAddr_r == iio_pkg::OFS_RELAY);
  wire selFlt = (awAddr_r == iio_pkg::OFS_FILTER);
  wire selIn  = (awAddr_r == iio_pkg::OFS_INPUT);
  wire wrOk   = selRly || selFlt || selIn;
  wire ld0    = wrGo && wStrb_r[0];
  // readies are registered from next-cycle state so every bus output leaves a flop
  wire awHeld_nxt = !wrGo && (awHeld_r || awTake);
  wire wHeld_nxt  = !wrGo && (wHeld_r || wTake);
  wire bValid_nxt = wrGo || (bValid_r && !s_axi_bready);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 4'h0;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r  <= iio_pkg::RESP_OKAY;
      awReady_r <= 1'b1;
      wReady_r  <= 1'b1;
    end else begin
      awReady_r <= !awHeld_nxt && !bValid_nxt;
      wReady_r  <= !wHeld_nxt && !bValid_nxt;
      if (awTake) begin
        awHeld_r <= 1'b1;
        awAddr_r <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (wTake) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrGo) begin
        awHeld_r <= 1'b0;
        wHeld_r  <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r  <= wrOk ? iio_pkg::RESP_OKAY : iio_pkg::RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // relays and filters rest off at reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl_r.relay  <= iio_pkg::RELAY_RST;
      ctrl_r.filtEn <= iio_pkg::FILTER_RST;
      relay_r       <= iio_pkg::RELAY_RST;
    end else begin
      if (ld0 && selRly) begin
        ctrl_r.relay <= wData_r[7:0];
      end
      if (ld0 && selFlt) begin
        ctrl_r.filtEn <= wData_r[7:0];
      end
      // high energises coil, contact form is wiring only
      relay_r <= ctrl_r.relay;
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready  = wReady_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign relayDrive    = relay_r;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic        rValid_r;
  logic [31:0] rData_r;
  logic [1:0]  rResp_r;
  logic        arReady_r;

  wire       arTake = s_axi_arvalid && !rValid_r;
  wire       rValid_nxt = arTake || (rValid_r && !s_axi_rready);
  wire [3:0] rAddr  = {s_axi_araddr[3:2], 2'h0};
  wire       rdIn   = (rAddr == iio_pkg::OFS_INPUT);
  wire       rdRly  = (rAddr == iio_pkg::OFS_RELAY);
  wire       rdFlt  = (rAddr == iio_pkg::OFS_FILTER);
  // whole input byte in one read
  // relay readback is the register, not inputs
  wire [7:0] rByte  = rdIn  ? inState :
                      rdRly ? ctrl_r.relay :
                      rdFlt ? ctrl_r.filtEn : 8'h00;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= iio_pkg::RESP_OKAY;
    end else if (arTake) begin
      rValid_r <= 1'b1;
      rData_r  <= {24'h00_0000, rByte};
      rResp_r  <= (rdIn || rdRly || rdFlt) ? iio_pkg::RESP_OKAY : iio_pkg::RESP_SLVERR;
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      arReady_r <= 1'b1;
    end else begin
      arReady_r <= !rValid_nxt;
    end
  end

  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // write reaches the drive two cycles on
  relay_write_a: assert property (@(posedge clock) disable iff (!rstn)
    (ld0 && selRly) |-> ##2 (relayDrive == $past(wData_r[7:0], 2)))
    else $error("relay drive missed write");
  relay_read_a: assert property (@(posedge clock) disable iff (!rstn)
    (arTake && rdRly) |=> (s_axi_rdata[7:0] == $past(ctrl_r.relay)))
    else $error("relay readback wrong");
  input_read_a: assert property (@(posedge clock) disable iff (!rstn)
    (arTake && rdIn) |=> (s_axi_rdata == {24'h00_0000, $past(inState)}))
    else $error("input byte wrong");
  drive_track_a: assert property (@(posedge clock) disable iff (!rstn)
    1'b1 |=> (relayDrive == $past(ctrl_r.relay)))
    else $error("drive not tracking register");
  drive_idle_a: assert property (@(posedge clock) disable iff (!rstn)
    (!(ld0 && selRly))[*2] ##0 $stable(ctrl_r.relay) |=> $stable(relayDrive))
    else $error("relay moved without write");
  // no relay energised out of reset
  reset_off_a: assert property (@(posedge clock)
    $rose(rstn) |-> (relayDrive == 8'h00))
    else $error("relay energised after reset");
  filter_write_a: assert property (@(posedge clock) disable iff (!rstn)
    (ld0 && selFlt) |=> (ctrl_r.filtEn == $past(wData_r[7:0])))
    else $error("filter enable missed write");
  // write answer one cycle after both halves
  write_resp_a: assert property (@(posedge clock) disable iff (!rstn)
    wrGo |=> s_axi_bvalid)
    else $error("write response late");
  reset_filt_a: assert property (@(posedge clock)
    $rose(rstn) |-> (ctrl_r.filtEn == 8'h00))
    else $error("filter enabled after reset");
  write_ready_a: assert property (@(posedge clock) disable iff (!rstn)
    (s_axi_awready == (!awHeld_r && !bValid_r)) &&
    (s_axi_wready == (!wHeld_r && !bValid_r)))
    else $error("write ready out of step");
  // read ready low while answer stands
  read_ready_a: assert property (@(posedge clock) disable iff (!rstn)
    s_axi_arready == !s_axi_rvalid)
    else $error("read ready out of step");
endmodule : iio_port

//--- verif/iio_field.sv
// Purpose: field-side model: input sources and relay contacts
// Assumes: relay coil energised by a high drive bit
// Notes:   sources change only at a rising edge
`timescale 1ns/1ns
module iio_field (
  // clock
  input  wire logic       clock,
  // wanted source levels and coil drives
  input  wire logic [7:0] level,
  input  wire logic [7:0] relayDrive,
  // pins and contact states
  output logic [7:0]      inPins,
  output logic [7:0]      comToNo,
  output logic [4:0]      comToNc
);
  always @(posedge clock) inPins <= level;
  assign comToNo = relayDrive;
  assign comToNc = ~relayDrive[4:0];
endmodule : iio_field

//--- verif/tb.sv
// Purpose: self-checking bench for the isolated input / relay output port
// Assumes: filter count shortened to 8 cycles
// Notes:   bus master tasks and field model drive every input except clock and rstn
`timescale 1ns/1ns
module tb;
  localparam int FC = 8;
  logic        clock = 1'b0, rstn = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [7:0]  lvl = 8'h00, inPins, relayDrive, comToNo;
  logic [4:0]  comToNc;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  int          n_errors = 0, comparisons = 0, seed = 32'hF182;
  int          mdlRelay, mdlIn, mdlFilt, old;
  always #25 clock = ~clock;
  iio_port #(.FILT_CYCLES(FC)) iio_port_inst (.clock(clock), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .inPins(inPins), .relayDrive(relayDrive));
  iio_field iio_field_inst (.clock(clock), .level(lvl), .relayDrive(relayDrive),
    .inPins(inPins), .comToNo(comToNo), .comToNc(comToNc));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // both halves offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic pa, pw;
    @(posedge clock);
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1 && !arvalid));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", 32'(iio_pkg::RESP_OKAY), 32'(r));
  endtask : rdc
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    #1 chk("relayDrive", 32'h0, 32'(relayDrive));
    rdc(iio_pkg::OFS_RELAY, 32'h0, "relay reg");
    rdc(iio_pkg::OFS_FILTER, 32'h0, "filter reg");
    for (int i = 0; i < 5; i++) begin
      mdlRelay = (i == 4) ? 32'hFF : $random(seed) & 32'hFF;
      mdlIn = ~mdlRelay & 32'hFF;
      lvl <= mdlIn[7:0];
      wr(iio_pkg::OFS_RELAY, mdlRelay, 4'hF, r);
      chk("bresp", 32'(iio_pkg::RESP_OKAY), 32'(r));
      repeat (8) @(posedge clock);
      chk("relayDrive", mdlRelay, 32'(relayDrive));
      chk("comToNo", mdlRelay, 32'(comToNo));
      chk("comToNc", ~mdlRelay & 32'h1F, 32'(comToNc));
      rdc(iio_pkg::OFS_RELAY, mdlRelay, "relay reg");
      rdc(iio_pkg::OFS_INPUT, mdlIn, "input byte");
    end
    wr(iio_pkg::OFS_RELAY, 32'h5A, 4'h0, r);
    chk("bresp", 32'(iio_pkg::RESP_OKAY), 32'(r));
    rdc(iio_pkg::OFS_RELAY, mdlRelay, "relay reg");
    wr(iio_pkg::OFS_INPUT, 32'hA5, 4'hF, r);
    chk("bresp", 32'(iio_pkg::RESP_OKAY), 32'(r));
    rdc(iio_pkg::OFS_INPUT, mdlIn, "input byte");
    wr(4'hC, 32'h1, 4'hF, r);
    chk("bresp", 32'(iio_pkg::RESP_SLVERR), 32'(r));
    rd(4'hC, d, r);
    chk("rresp", 32'(iio_pkg::RESP_SLVERR), 32'(r));
    chk("rdata", 32'h0, d);
    mdlFilt = 32'h0F;
    wr(iio_pkg::OFS_FILTER, mdlFilt, 4'hF, r);
    chk("bresp", 32'(iio_pkg::RESP_OKAY), 32'(r));
    rdc(iio_pkg::OFS_FILTER, mdlFilt, "filter reg");
    old = mdlIn;
    mdlIn = ~old & 32'hFF;
    lvl <= mdlIn[7:0];
    repeat (6) @(posedge clock);
    rdc(iio_pkg::OFS_INPUT, (mdlIn & ~mdlFilt) | (old & mdlFilt), "input byte");
    repeat (3 * FC) @(posedge clock);
    rdc(iio_pkg::OFS_INPUT, mdlIn, "input byte");
    // reset with every relay energised and filters 0-3 on must drop both
    rstn <= 1'b0;
    repeat (3) @(posedge clock);
    chk("relayDrive", 32'h0, 32'(relayDrive));
    chk("comToNc", 32'h1F, 32'(comToNc));
    rstn <= 1'b1;
    rdc(iio_pkg::OFS_RELAY, 32'h0, "relay reg");
    rdc(iio_pkg::OFS_FILTER, 32'h0, "filter reg");
    rdc(iio_pkg::OFS_INPUT, mdlIn, "input byte");
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    complete_run();
  end
endmodule : tb
